// ### testbench/testbench.sv
// Purpose: register sequences for the watchdog block
// Assumes: select code 0 gives 2048 slow rises
// Notes:   runs near 75k clk cycles
`timescale 1ns/1ps
module testbench;
    import watchdog_cause_flag_pkg::*;
    logic        clk;
    logic        rst;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [3:0]  wbSel;
    logic [3:0]  wrSel;
    logic        kick;
    logic        gie;
    logic [9:0]  wbAdr;
    logic [31:0] wbDatI;
    logic [31:0] datOut;
    logic        ack;
    logic        osc;
    logic        fuse;
    logic        brown;
    logic        extPin;
    logic        vecAck;
    logic        irq;
    logic        chipRst;
    logic [7:0]  q;
    int          n;
    int          failures = 0;
    int          numChecks = 0;

    watchdog_cause_flag_watchdog_reset_flags watchdog_cause_flag_watchdog_reset_flags_inst (
        .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO_q(datOut),
        .wbAck_q(ack), .slowOsc(osc), .alwaysOnFuse(fuse), .dogKick(kick),
        .brownoutReset(brown), .extPinReset(extPin),
        .globalIrqEnable(gie), .vectorAck(vecAck), .irqReq_q(irq),
        .chipResetReq_q(chipRst));
    watchdog_cause_flag_far_side watchdog_cause_flag_far_side_inst (.clk(clk), .rst(rst),
        .irqReq_q(irq), .slowOsc(osc), .vectorAck(vecAck));

    task automatic give_verdict();
        $display("checks %0d errors %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
        int k;
        @(posedge clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbSel  <= wrSel;
        wbAdr  <= {idx, 2'b00};
        wbDatI <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1)
        begin
            failures++;
            give_verdict();
        end
        q = datOut[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(q, exp);
    endtask : rd

    task automatic wait_out(input logic pickRst);
        n = 0;
        while ((pickRst ? chipRst : irq) !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 40000)
            begin
                failures++;
                give_verdict();
            end
        end
    endtask : wait_out

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, fuse, brown, extPin, kick} = 7'h0;
        gie = 1'b1;
        wbSel = 4'h0;
        wrSel = 4'h1;
        wbAdr = 10'h0;
        wbDatI = 32'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(CAUSE_INDEX, 8'h01);
        rd(CTRL_INDEX, 8'h00);
        rd(8'h30, 8'h00);
        // a write without the low byte lane is acked and ignored
        wrSel = 4'he;
        wb(1'b1, CAUSE_INDEX, 8'h00);
        wrSel = 4'h1;
        rd(CAUSE_INDEX, 8'h01);
        wb(1'b1, CAUSE_INDEX, 8'h00);
        rd(CAUSE_INDEX, 8'h00);
        @(posedge clk);
        brown <= 1'b1;
        @(posedge clk);
        brown <= 1'b0;
        extPin <= 1'b1;
        @(posedge clk);
        extPin <= 1'b0;
        rd(CAUSE_INDEX, 8'h06);
        wb(1'b1, CAUSE_INDEX, 8'h00);
        wb(1'b1, CTRL_INDEX, 8'h08);
        rd(CTRL_INDEX, 8'h08);
        // clearing the enable or changing the select outside the window is refused
        wb(1'b1, CTRL_INDEX, 8'h01);
        rd(CTRL_INDEX, 8'h08);
        wb(1'b1, CTRL_INDEX, 8'h18);
        wb(1'b1, CTRL_INDEX, 8'h01);
        rd(CTRL_INDEX, 8'h01);
        wb(1'b1, CTRL_INDEX, 8'h19);
        repeat (6) @(posedge clk);
        rd(CTRL_INDEX, 8'h09);
        wb(1'b1, CTRL_INDEX, 8'h01);
        rd(CTRL_INDEX, 8'h09);
        wb(1'b1, CTRL_INDEX, 8'h19);
        wb(1'b1, CTRL_INDEX, 8'h00);
        // irq mode with the global enable off: flag only, no request
        gie <= 1'b0;
        wb(1'b1, CTRL_INDEX, 8'h40);
        repeat (16600) @(posedge clk);
        check({7'h0, irq}, 8'h00);
        rd(CTRL_INDEX, 8'hc0);
        wb(1'b1, CTRL_INDEX, 8'hc0);
        rd(CTRL_INDEX, 8'h40);
        gie <= 1'b1;
        wait_out(1'b0);
        repeat (2) @(posedge clk);
        rd(CTRL_INDEX, 8'h40);
        wb(1'b1, CTRL_INDEX, 8'h00);
        wb(1'b1, CTRL_INDEX, 8'h48);
        wait_out(1'b0);
        check(8'(n > 16000 && n < 16600), 8'h01);
        repeat (2) @(posedge clk);
        rd(CTRL_INDEX, 8'h08);
        // a kick halfway through pushes the reset a full period out
        repeat (8000) @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        wait_out(1'b1);
        check(8'(n > 16000 && n < 16600), 8'h01);
        rd(CAUSE_INDEX, 8'h08);
        rd(CTRL_INDEX, 8'h08);
        wb(1'b1, CAUSE_INDEX, 8'h00);
        rd(CTRL_INDEX, 8'h00);
        fuse <= 1'b1;
        rd(CTRL_INDEX, 8'h08);
        wb(1'b1, CTRL_INDEX, 8'h18);
        wb(1'b1, CTRL_INDEX, 8'h00);
        rd(CTRL_INDEX, 8'h08);
        give_verdict();
    end
endmodule : testbench

// ### testbench/watchdog_cause_flag_far_side.sv
// Purpose: slow oscillator and interrupt controller model
// Assumes: oscillator period of eight clk, free running
// Notes:   takes the vector one cycle after a request
`timescale 1ns/1ps
module watchdog_cause_flag_far_side (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic irqReq_q,
    output logic      slowOsc,
    output logic      vectorAck
);
    logic [1:0] div;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div       <= 2'h0;
            slowOsc   <= 1'b0;
            vectorAck <= 1'b0;
        end
        else
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
                slowOsc <= ~slowOsc;
            vectorAck <= irqReq_q && !vectorAck;
        end
    end
endmodule : watchdog_cause_flag_far_side

// ### testbench/watchdog_cause_flag_monitor.sv
// Purpose: port checks for the watchdog block
// Assumes: one clock, rst async active high
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module watchdog_cause_flag_monitor
    import watchdog_cause_flag_pkg::*;
#(
    parameter int WB_ADR_W = 10
)(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                wbCyc,
    input wire logic                wbStb,
    input wire logic                wbWe,
    input wire logic [3:0]          wbSel,
    input wire logic [WB_ADR_W-1:0] wbAdr,
    input wire logic [31:0]         wbDatI,
    input wire logic [31:0]         wbDatO_q,
    input wire logic                wbAck_q,
    input wire logic                slowOsc,
    input wire logic                alwaysOnFuse,
    input wire logic                dogKick,
    input wire logic                brownoutReset,
    input wire logic                extPinReset,
    input wire logic                globalIrqEnable,
    input wire logic                vectorAck,
    input wire logic                irqReq_q,
    input wire logic                chipResetReq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rdCtrl;
    logic rdCause;
    assign rdCtrl  = wbAck_q && !wbWe && wbAdr[9:2] == CTRL_INDEX;
    assign rdCause = wbAck_q && !wbWe && wbAdr[9:2] == CAUSE_INDEX;
    chk_ack_answer: assert property (wbCyc && wbStb && !wbAck_q |=> wbAck_q)
        else $error("request not acked next cycle");
    chk_ack_single: assert property (wbAck_q |=> !wbAck_q)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (!(wbCyc && wbStb) |=> !wbAck_q)
        else $error("ack without request");
    chk_data_upper: assert property (wbAck_q |-> wbDatO_q[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_cause_reserved: assert property (
        rdCause |-> wbDatO_q[7:4] == 4'h0) else $error("reserved bits set");
    chk_fuse_enable: assert property (
        rdCtrl && alwaysOnFuse |-> wbDatO_q[CTRL_DE_BIT])
        else $error("enable reads zero with fuse on");
    chk_reset_pulse: assert property (chipResetReq_q |=> !chipResetReq_q)
        else $error("reset request longer than one cycle");
    chk_irq_gate: assert property (irqReq_q |-> $past(globalIrqEnable))
        else $error("irq without global enable");
    chk_irq_taken: assert property (vectorAck |=> !irqReq_q)
        else $error("irq stays after vector taken");
endmodule : watchdog_cause_flag_monitor

bind watchdog_cause_flag_watchdog_reset_flags watchdog_cause_flag_monitor #(.WB_ADR_W(WB_ADR_W)) mon_inst (
    .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO_q(wbDatO_q),
    .wbAck_q(wbAck_q), .slowOsc(slowOsc), .alwaysOnFuse(alwaysOnFuse),
    .dogKick(dogKick), .brownoutReset(brownoutReset),
    .extPinReset(extPinReset), .globalIrqEnable(globalIrqEnable),
    .vectorAck(vectorAck), .irqReq_q(irqReq_q),
    .chipResetReq_q(chipResetReq_q));

// ### verilog/watchdog_cause_flag_pkg.sv
// Purpose: shared constants and carriers for the watchdog and reset flags
// Assumes: 32-bit classic Wishbone, registers in the low byte of a word
// Notes:   register byte address is four times its index
package watchdog_cause_flag_pkg;

    // register indices and byte addresses
    localparam logic [7:0] CTRL_INDEX  = 8'h21;
    localparam logic [7:0] CAUSE_INDEX = 8'h22;
    localparam logic [9:0] CTRL_ADDR   = {CTRL_INDEX, 2'b00};
    localparam logic [9:0] CAUSE_ADDR  = {CAUSE_INDEX, 2'b00};

    // field positions of the control/status byte
    localparam int CTRL_FLAG_BIT = 7;
    localparam int CTRL_IE_BIT   = 6;
    localparam int CTRL_SELH_BIT = 5;
    localparam int CTRL_CE_BIT   = 4;
    localparam int CTRL_DE_BIT   = 3;

    // field positions of the reset cause byte
    localparam int CAUSE_DOG_BIT = 3;
    localparam int CAUSE_BOR_BIT = 2;
    localparam int CAUSE_EXT_BIT = 1;
    localparam int CAUSE_POR_BIT = 0;

    // values after reset
    localparam logic [3:0] SEL_RESET   = 4'h0;
    localparam logic [3:0] CAUSE_RESET = 4'h1;

    // timing
    localparam int         OSC_FREQ_KHZ  = 128;
    localparam logic [2:0] CE_WINDOW_CYC = 3'h4;
    localparam logic [3:0] SEL_MAX_VALID = 4'h9;
    localparam int         CNT_W         = 20;
    localparam logic [19:0] CNT_ALL_ONES = 20'hfffff;

    typedef struct packed {
        logic       irqFlag;
        logic       irqEnable;
        logic       selHi;
        logic       changeEnable;
        logic       dogEnable;
        logic [2:0] selLo;
    } watchdog_cause_flag_ctrl_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic       dogCause;
        logic       brownoutCause;
        logic       extPinCause;
        logic       powerOnCause;
    } watchdog_cause_flag_cause_t;

endpackage : watchdog_cause_flag_pkg

// ### verilog/watchdog_cause_flag_watchdog_reset_flags.sv
// Purpose: watchdog timer with interrupt/reset modes and reset cause flags
// Assumes: rst is the power-on reset; other reset causes arrive as pulses
//          on clk; the oscillator arrives as a slow asynchronous level
// Notes:   registers sit on classic Wishbone, acked one cycle after strobe
`timescale 1ns/1ps

module watchdog_cause_flag_watchdog_reset_flags
    import watchdog_cause_flag_pkg::*;
#(
    parameter int WB_ADR_W = 10
)(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                wbCyc,
    input  wire logic                wbStb,
    input  wire logic                wbWe,
    input  wire logic [3:0]          wbSel,
    input  wire logic [WB_ADR_W-1:0] wbAdr,
    input  wire logic [31:0]         wbDatI,
    output logic      [31:0]         wbDatO_q,
    output logic                     wbAck_q,
    input  wire logic                slowOsc,
    input  wire logic                alwaysOnFuse,
    input  wire logic                dogKick,
    input  wire logic                brownoutReset,
    input  wire logic                extPinReset,
    input  wire logic                globalIrqEnable,
    input  wire logic                vectorAck,
    output logic                     irqReq_q,
    output logic                     chipResetReq_q
);

    initial
    begin
        if (WB_ADR_W < 10)
            $error("WB_ADR_W must reach the register byte addresses");
        // the counter must hold the longest timeout, 2^(11+9) rises
        if (CNT_W != 11 + int'(SEL_MAX_VALID))
            $error("CNT_W does not fit the longest timeout");
    end

    watchdog_cause_flag_ctrl_t         ctrl_q;
    watchdog_cause_flag_ctrl_t         ctrl_d;
    watchdog_cause_flag_cause_t        cause_q;
    watchdog_cause_flag_cause_t        cause_d;
    logic [2:0]         ceCnt_q;
    logic [2:0]         ceCnt_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   cnt_d;
    logic [2:0]         oscSync_q;
    logic               oscLvl_q;
    logic               oscLvl_d;
    logic [31:0]        wbDatO_d;
    logic               wbAck_d;
    logic               irqReq_d;
    logic               chipResetReq_d;
    logic               irqArmed_q;
    logic               irqArmed_d;

    logic               access;
    logic               commit;
    logic               hitCtrl;
    logic               hitCause;
    logic               oscTick;
    logic               dogEff;
    logic               running;
    logic [3:0]         selRaw;
    logic [3:0]         selEff;
    logic [CNT_W-1:0]   termCnt;
    logic               timeout;
    logic               chipReset;
    watchdog_cause_flag_ctrl_t         wCtrl;
    watchdog_cause_flag_cause_t        wCause;
    watchdog_cause_flag_ctrl_t         rdCtrl;

    assign access   = wbCyc & wbStb;
    // a write lands at the edge where the master sees ack
    assign commit   = access & wbAck_q & wbWe & wbSel[0];
    assign hitCtrl  = wbAdr[WB_ADR_W-1:2] == CTRL_ADDR[9:2];
    assign hitCause = wbAdr[WB_ADR_W-1:2] == CAUSE_ADDR[9:2];
    assign wCtrl    = watchdog_cause_flag_ctrl_t'(wbDatI[7:0]);
    assign wCause   = watchdog_cause_flag_cause_t'(wbDatI[7:0]);

    assign dogEff  = ctrl_q.dogEnable | alwaysOnFuse | cause_q.dogCause;
    assign running = dogEff | ctrl_q.irqEnable;

    assign selRaw = {ctrl_q.selHi, ctrl_q.selLo};
    assign selEff = (selRaw > SEL_MAX_VALID) ? SEL_MAX_VALID : selRaw;
    assign termCnt = CNT_ALL_ONES >> (SEL_MAX_VALID - selEff);

    // tick on each settled oscillator rise
    assign oscTick = oscLvl_d & ~oscLvl_q;
    // >= rather than == so a shorter select bites on the next tick
    // instead of letting the counter run round its full width
    assign timeout = running & oscTick & (cnt_q >= termCnt);

    always_comb
    begin
        rdCtrl           = ctrl_q;
        rdCtrl.dogEnable = dogEff;
    end

    // oscillator sampling, three flops then agreement filter
    always_comb
    begin
        oscLvl_d = oscLvl_q;
        if (oscSync_q[1] == oscSync_q[2])
            oscLvl_d = oscSync_q[2];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            oscSync_q <= 3'h0;
            oscLvl_q  <= 1'b0;
        end
        else
        begin
            oscSync_q <= {oscSync_q[1:0], slowOsc};
            oscLvl_q  <= oscLvl_d;
        end
    end

    // bus slave: ack one cycle after the strobe, dropped the next
    always_comb
    begin
        wbAck_d  = access & ~wbAck_q;
        wbDatO_d = wbDatO_q;
        if (access & ~wbAck_q)
        begin
            wbDatO_d = 32'h0;
            if (hitCtrl)
                wbDatO_d[7:0] = rdCtrl;
            else if (hitCause)
                wbDatO_d[7:0] = {4'h0, cause_q[3:0]};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wbAck_q  <= 1'b0;
            wbDatO_q <= 32'h0;
        end
        else
        begin
            wbAck_q  <= wbAck_d;
            wbDatO_q <= wbDatO_d;
        end
    end

    // watchdog core, registers and reset cause flags
    always_comb
    begin
        ctrl_d         = ctrl_q;
        cause_d        = cause_q;
        ceCnt_d        = ceCnt_q;
        cnt_d          = cnt_q;
        chipResetReq_d = 1'b0;
        irqArmed_d     = irqArmed_q;

        if (ctrl_q.changeEnable)
        begin
            if (ceCnt_q == 3'h1)
            begin
                ctrl_d.changeEnable = 1'b0;
                ceCnt_d             = 3'h0;
            end
            else
                ceCnt_d = ceCnt_q - 3'h1;
        end

        if (commit & hitCtrl)
        begin
            if (wCtrl.irqFlag)
                ctrl_d.irqFlag = 1'b0;
            ctrl_d.irqEnable = wCtrl.irqEnable;
            if (wCtrl.dogEnable)
                ctrl_d.dogEnable = 1'b1;
            // zero accepted only in the window
            else if (ctrl_q.changeEnable)
                ctrl_d.dogEnable = 1'b0;
            if (ctrl_q.changeEnable)
            begin
                ctrl_d.selHi = wCtrl.selHi;
                ctrl_d.selLo = wCtrl.selLo;
            end
            // window opens on both bits written one
            if (wCtrl.changeEnable & wCtrl.dogEnable)
            begin
                ctrl_d.changeEnable = 1'b1;
                ceCnt_d             = CE_WINDOW_CYC;
            end
            else if (!wCtrl.changeEnable)
            begin
                ctrl_d.changeEnable = 1'b0;
                ceCnt_d             = 3'h0;
            end
        end

        if (commit & hitCause)
        begin
            if (!wCause.dogCause)
                cause_d.dogCause = 1'b0;
            if (!wCause.brownoutCause)
                cause_d.brownoutCause = 1'b0;
            if (!wCause.extPinCause)
                cause_d.extPinCause = 1'b0;
            if (!wCause.powerOnCause)
                cause_d.powerOnCause = 1'b0;
        end

        if (vectorAck)
            ctrl_d.irqFlag = 1'b0;

        // restart on kick or when stopped
        if (!running || dogKick)
            cnt_d = '0;
        else if (oscTick)
            cnt_d = timeout ? '0 : cnt_q + 1'b1;

        if (timeout)
        begin
            if (ctrl_q.irqEnable)
            begin
                // flag set wins over a write or vectorAck clear; a brownout or pin reset in the same cycle still clears it
                ctrl_d.irqFlag = 1'b1;
                // drop irq enable so the next one resets
                if (dogEff)
                begin
                    ctrl_d.irqEnable = 1'b0;
                    // this timeout still owes its interrupt
                    irqArmed_d       = 1'b1;
                end
            end
            else
            begin
                chipResetReq_d   = 1'b1;
                cause_d.dogCause = 1'b1;
            end
        end

        if (brownoutReset)
            cause_d.brownoutCause = 1'b1;
        if (extPinReset)
            cause_d.extPinCause = 1'b1;

        // a chip reset returns the control byte to its initial state
        if (chipReset)
        begin
            ctrl_d              = '0;
            {ctrl_d.selHi, ctrl_d.selLo} = SEL_RESET;
            ceCnt_d             = 3'h0;
            cnt_d               = '0;
        end

        // the owed interrupt lapses once its flag is gone
        if (!ctrl_d.irqFlag)
            irqArmed_d = 1'b0;
    end

    // brownout and pin resets arrive as clk pulses and rewind the
    // control byte like a watchdog reset; only the watchdog requests one
    assign chipReset = brownoutReset | extPinReset |
                       (timeout & ~ctrl_q.irqEnable);

    // both enables gate the request; the armed bit stands in for
    // an irq enable that this very timeout cleared, so with both mode
    // bits set the interrupt still comes before the next timeout resets
    assign irqReq_d = ctrl_d.irqFlag & (ctrl_d.irqEnable | irqArmed_d) &
                      globalIrqEnable;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q         <= '0;
            // power-on sets its own flag only
            cause_q        <= {4'h0, CAUSE_RESET};
            ceCnt_q        <= 3'h0;
            cnt_q          <= '0;
            irqArmed_q     <= 1'b0;
            irqReq_q       <= 1'b0;
            chipResetReq_q <= 1'b0;
        end
        else
        begin
            ctrl_q         <= ctrl_d;
            cause_q        <= cause_d;
            ceCnt_q        <= ceCnt_d;
            cnt_q          <= cnt_d;
            irqArmed_q     <= irqArmed_d;
            irqReq_q       <= irqReq_d;
            chipResetReq_q <= chipResetReq_d;
        end
    end

endmodule : watchdog_cause_flag_watchdog_reset_flags
